//--- pulse_width_adjust_control.sv
// pulse width adjust control: load-bank select, reverse-voltage stepping, width approach
// assumes one 100 MHz clock, synchronous inputs, a single AHB-Lite master
//
// Summary of operation
// [R01] reload source is primary preload when bank select is 0, secondary when 1
// [R02] enabled fault input falling edge sets bank select to 1
// [R03] reverse-detect falling edge adds step size and starts interval counter
// [R04] while reverse-detect low, add step size each elapsed interval
// [R05] stop stepping at 1FF or when reverse-detect returns high; counter off
// [R06] approach only while reverse-detect high; reverse stepping takes over at once
// [R07] software mode: enable bit sets active flag; ramp toward selected target
// [R08] software leaves width and step fields alone during software approach
// [R09] software approach keeps reached flags clear until target met, then sets one
// [R10] software mode: phase timer reloads first preload, overflow pulses output
// [R11] software writes high bits before low byte of each width value
// [R12] software configures fields, mode, target, then sets enable last
// [R13] hardware mode timer starts on input rising edge or run bit rise
// [R14] first interval counts from first preload; width held
// [R15] second interval ramps toward first target, holds at target or overflow
// [R16] after set number of steps, trigger count and step value are changed
// [R17] third interval ramps toward second target, holds at target or overflow
// [R18] final interval timer off; parameters may change then or in the first interval
// [R19] software finishes approach setup before second interval
// [R20] second interval sets first reached flag; software clears; start clears
// [R21] third interval sets second reached flag; software clears; start clears
// [R22] clearing hardware mode bit stops hardware approach
// [R23] setting hardware mode bit clears the run bit
// [R24] timer state field reads 00, 01, 10, 11
// [R25] reverse stepping clamps width at 1FF
`timescale 1ns/100ps
`include "pwa_consts.svh"
module pulse_width_adjust_control (
  // clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // comparator and trigger inputs
  input wire logic [2:0] comparator_fault_input,
  input wire logic reverse_voltage_detect,
  input wire logic phase_timer_trigger_input,
  input wire logic pulse_trigger,
  input wire logic phase_timer_tick,
  // results
  output logic [8:0] reload_width,
  output logic phase_timer_overflow_signal
);
  pwa_pkg::ctl_t ctl_reg, ctl_next;
  pwa_pkg::cfg_t cfg_reg, cfg_next;
  pwa_pkg::timer_state_t tstate_reg, tstate_next;
  logic [7:0] timer_reg, timer_next;
  logic [7:0] rv_cnt_reg, rv_cnt_next;
  logic rv_active_reg, rv_active_next;
  logic sw_active_reg, sw_active_next;
  logic f1_reg, f1_next, f2_reg, f2_next;
  logic [1:0] trig_cnt_reg, trig_cnt_next;
  logic [2:0] step_cnt_reg, step_cnt_next;
  logic [2:0] fault_prev_reg;
  logic rv_prev_reg, trig_prev_reg;
  logic [8:0] reload_next;
  logic ovf_next;
  logic wr_pend_reg, rd_pend_reg;
  logic [7:0] dp_addr_reg;
  logic wr_pend_next, rd_pend_next, hready_next;
  logic [7:0] dp_addr_next;
  logic [31:0] hrdata_next;
  logic wr_en, wr_ctrl, hw_rise, run_rise, hw_start, locked, ramping, at_target;
  logic hw_stop;
  logic [8:0] target;

  function automatic logic [8:0] sat_add(input logic [8:0] a, input logic [3:0] b);
    logic [9:0] s;
    s = {1'b0, a} + {6'h00, b};
    sat_add = s[9] ? `W_MAX : s[8:0];
  endfunction

  function automatic logic [8:0] toward(input logic [8:0] a, input logic [8:0] t, input logic [2:0] sa);
    logic [9:0] up;
    logic [8:0] st;
    st = {6'h00, sa} + 9'h001;
    up = {1'b0, a} + {1'b0, st};
    if (a < t) begin
      toward = (up >= {1'b0, t}) ? t : up[8:0];
    end else begin
      toward = (a - t <= st) ? t : a - st;
    end
  endfunction

  function automatic logic [7:0] interval_cycles(input logic [3:0] ivl);
    interval_cycles = (ivl == 4'h0) ? `RV_UNIT : 8'({ivl, 4'h0});
  endfunction

  function automatic logic [31:0] read_mux(input logic [7:0] a, input pwa_pkg::ctl_t c,
                                           input pwa_pkg::cfg_t g, input logic [13:9] st,
                                           input logic [7:0] tm);
    read_mux = 32'h0000_0000;
    unique case (a)
      `OFF_CTRL: read_mux = {18'h00000, st, c.phase_timer_run, c.phase_trigger_select, // R24
                             c.approach_target_select, c.approach_enable, c.approach_hw_mode,
                             c.fault_reload_enable, c.load_bank_select};
      `OFF_HIGH: read_mux = {31'h0000_0000, g.width_high_bits};
      `OFF_PRI: read_mux = {23'h000000, g.primary_width_preload};
      `OFF_SEC: read_mux = {23'h000000, g.secondary_width_preload};
      `OFF_TGT1: read_mux = {23'h000000, g.first_approach_target};
      `OFF_TGT2: read_mux = {23'h000000, g.second_approach_target};
      `OFF_RV: read_mux = {24'h000000, g.reverse_step_interval, g.reverse_step_size};
      `OFF_APR: read_mux = {20'h00000, g.step_value_change, g.trigger_count_change,
                            g.adjust_after_steps, g.approach_step_value, g.triggers_per_step};
      `OFF_PRE: read_mux = {8'h00, g.third_phase_preload, g.second_phase_preload,
                            g.first_phase_preload};
      `OFF_TMR: read_mux = {24'h000000, tm};
      default: read_mux = 32'h0000_0000;
    endcase
  endfunction

  // bus: writes take effect in the data phase, reads add one wait state
  always_comb begin
    wr_pend_next = 1'b0;
    rd_pend_next = 1'b0;
    hready_next = 1'b1;
    dp_addr_next = dp_addr_reg;
    hrdata_next = hrdata;
    if (rd_pend_reg) begin
      hrdata_next = read_mux(dp_addr_reg, ctl_reg, cfg_reg,
                             {f2_reg, f1_reg, tstate_reg, sw_active_reg | ramping}, timer_reg);
    end else if (hsel && htrans[1] && hready) begin
      dp_addr_next = haddr[7:0];
      wr_pend_next = hwrite;
      rd_pend_next = !hwrite;
      hready_next = hwrite;
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      wr_pend_reg <= 1'b0;
      rd_pend_reg <= 1'b0;
      dp_addr_reg <= 8'h00;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      hrdata <= 32'h0000_0000;
    end else begin
      wr_pend_reg <= wr_pend_next;
      rd_pend_reg <= rd_pend_next;
      dp_addr_reg <= dp_addr_next;
      hreadyout <= hready_next;
      hresp <= 1'b0;
      hrdata <= hrdata_next;
    end
  end

  assign wr_en = wr_pend_reg;
  assign wr_ctrl = wr_en && dp_addr_reg == `OFF_CTRL;
  assign hw_rise = wr_ctrl && !ctl_reg.approach_hw_mode && hwdata[`B_HW];
  assign run_rise = wr_ctrl && !hw_rise && !ctl_reg.phase_timer_run && hwdata[`B_RUN];
  assign hw_stop = wr_ctrl && !hwdata[`B_HW]; // R22
  assign hw_start = ctl_reg.approach_hw_mode && !hw_rise && !hw_stop && (ctl_reg.phase_trigger_select ? run_rise
                    : (phase_timer_trigger_input && !trig_prev_reg)); // R13
  assign locked = ctl_reg.approach_hw_mode && (tstate_reg == pwa_pkg::TS_TOWARD1 ||
                  tstate_reg == pwa_pkg::TS_TOWARD2); // R18 R19
  assign ramping = ctl_reg.approach_hw_mode ? locked : sw_active_reg;
  assign target = (ctl_reg.approach_hw_mode ? tstate_reg == pwa_pkg::TS_TOWARD2
                   : ctl_reg.approach_target_select) ? cfg_reg.second_approach_target
                   : cfg_reg.first_approach_target;
  assign at_target = cfg_reg.primary_width_preload == target;

  // core: register writes, bank select, phase timer, reverse stepping, approach
  always_comb begin
    ctl_next = ctl_reg;
    cfg_next = cfg_reg;
    tstate_next = tstate_reg;
    timer_next = timer_reg;
    rv_cnt_next = rv_cnt_reg;
    rv_active_next = rv_active_reg;
    sw_active_next = sw_active_reg;
    f1_next = f1_reg;
    f2_next = f2_reg;
    trig_cnt_next = trig_cnt_reg;
    step_cnt_next = step_cnt_reg;
    ovf_next = 1'b0;
    if (wr_ctrl) begin
      ctl_next.load_bank_select = hwdata[`B_LBS];
      ctl_next.fault_reload_enable = hwdata[`B_FRE];
      ctl_next.approach_hw_mode = hwdata[`B_HW];
      ctl_next.approach_enable = hwdata[`B_EN];
      ctl_next.approach_target_select = hwdata[`B_TSEL];
      ctl_next.phase_trigger_select = hwdata[`B_TRIG];
      ctl_next.phase_timer_run = hw_rise ? 1'b0 : hwdata[`B_RUN]; // R23
      if (!hwdata[`B_F1]) f1_next = 1'b0;
      if (!hwdata[`B_F2]) f2_next = 1'b0;
      if (!hwdata[`B_HW]) tstate_next = pwa_pkg::TS_OFF; // R22
      if (hw_rise) tstate_next = pwa_pkg::TS_OFF;
      sw_active_next = hwdata[`B_EN] && !hwdata[`B_HW]; // R07
      if (run_rise) timer_next = cfg_reg.first_phase_preload;
    end
    if (wr_en) begin
      unique case (dp_addr_reg)
        `OFF_HIGH: cfg_next.width_high_bits = hwdata[0];
        `OFF_PRI: if (!locked) cfg_next.primary_width_preload = {cfg_reg.width_high_bits, hwdata[7:0]};
        `OFF_SEC: cfg_next.secondary_width_preload = {cfg_reg.width_high_bits, hwdata[7:0]};
        `OFF_TGT1: cfg_next.first_approach_target = {cfg_reg.width_high_bits, hwdata[7:0]};
        `OFF_TGT2: cfg_next.second_approach_target = {cfg_reg.width_high_bits, hwdata[7:0]};
        `OFF_RV: begin
          cfg_next.reverse_step_size = hwdata[`F_STEP];
          cfg_next.reverse_step_interval = hwdata[`F_IVL];
        end
        `OFF_APR: if (!locked) begin
          cfg_next.triggers_per_step = hwdata[`F_TPS];
          cfg_next.approach_step_value = hwdata[`F_SA];
          cfg_next.adjust_after_steps = hwdata[`F_AFTER];
          cfg_next.trigger_count_change = hwdata[`F_TCC];
          cfg_next.step_value_change = hwdata[`F_SVC];
        end
        `OFF_PRE: begin
          cfg_next.first_phase_preload = hwdata[`F_PRE1];
          cfg_next.second_phase_preload = hwdata[`F_PRE2];
          cfg_next.third_phase_preload = hwdata[`F_PRE3];
        end
        default: ;
      endcase
    end
    if (|(fault_prev_reg & ~comparator_fault_input & ctl_reg.fault_reload_enable)) begin
      ctl_next.load_bank_select = 1'b1; // R02
    end
    // phase timer
    if (!ctl_reg.approach_hw_mode) begin
      if (ctl_reg.phase_timer_run && phase_timer_tick && !run_rise) begin
        if (timer_reg == `T_MAX) begin
          timer_next = cfg_reg.first_phase_preload; // R10
          ovf_next = 1'b1;
        end else begin
          timer_next = timer_reg + 8'h01;
        end
      end
    end else if (hw_start) begin
      tstate_next = pwa_pkg::TS_FIRST; // R14
      timer_next = cfg_reg.first_phase_preload;
      ctl_next.phase_timer_run = 1'b1;
      f1_next = 1'b0; // R20
      f2_next = 1'b0; // R21
      trig_cnt_next = 2'b00;
      step_cnt_next = 3'b000;
    end else if (tstate_reg != pwa_pkg::TS_OFF && phase_timer_tick && !hw_stop) begin
      if (timer_reg == `T_MAX) begin
        ovf_next = 1'b1;
        trig_cnt_next = 2'b00;
        step_cnt_next = 3'b000;
        unique case (tstate_reg)
          pwa_pkg::TS_FIRST: begin
            tstate_next = pwa_pkg::TS_TOWARD1; // R15
            timer_next = cfg_reg.second_phase_preload;
          end
          pwa_pkg::TS_TOWARD1: begin
            tstate_next = pwa_pkg::TS_TOWARD2; // R17
            timer_next = cfg_reg.third_phase_preload;
          end
          default: begin
            tstate_next = pwa_pkg::TS_OFF; // R18
            ctl_next.phase_timer_run = 1'b0;
          end
        endcase
      end else begin
        timer_next = timer_reg + 8'h01;
      end
    end
    // reverse-voltage stepping outranks approach
    if (rv_prev_reg && !reverse_voltage_detect) begin
      cfg_next.primary_width_preload = sat_add(cfg_reg.primary_width_preload,
                                               cfg_reg.reverse_step_size); // R03 R25
      rv_active_next = 1'b1;
      rv_cnt_next = 8'h01;
    end else if (rv_active_reg) begin
      if (reverse_voltage_detect || cfg_reg.primary_width_preload == `W_MAX) begin
        rv_active_next = 1'b0; // R05
        rv_cnt_next = 8'h00;
      end else if (rv_cnt_reg >= interval_cycles(cfg_reg.reverse_step_interval)) begin
        cfg_next.primary_width_preload = sat_add(cfg_reg.primary_width_preload,
                                                 cfg_reg.reverse_step_size); // R04 R25
        rv_cnt_next = 8'h01;
      end else begin
        rv_cnt_next = rv_cnt_reg + 8'h01;
      end
    end else if (reverse_voltage_detect && ramping && !hw_start) begin // R06
      if (at_target) begin
        if (ctl_reg.approach_hw_mode ? tstate_reg == pwa_pkg::TS_TOWARD2
            : ctl_reg.approach_target_select) begin
          f2_next = 1'b1; // R09 R21
        end else begin
          f1_next = 1'b1; // R09 R20
        end
      end else begin
        if (!ctl_reg.approach_hw_mode) begin
          f1_next = 1'b0; // R09
          f2_next = 1'b0;
        end
        if (pulse_trigger) begin
          if (trig_cnt_reg >= cfg_reg.triggers_per_step) begin
            trig_cnt_next = 2'b00;
            cfg_next.primary_width_preload = toward(cfg_reg.primary_width_preload, target,
                                                    cfg_reg.approach_step_value); // R15 R17
            if (step_cnt_reg >= cfg_reg.adjust_after_steps) begin
              step_cnt_next = 3'b000; // R16
              unique case (cfg_reg.trigger_count_change)
                2'b01: if (cfg_reg.triggers_per_step != 2'b00) cfg_next.triggers_per_step
                         = cfg_reg.triggers_per_step - 2'b01;
                2'b10: if (cfg_reg.triggers_per_step != 2'b11) cfg_next.triggers_per_step
                         = cfg_reg.triggers_per_step + 2'b01;
                default: ;
              endcase
              unique case (cfg_reg.step_value_change)
                2'b01: if (cfg_reg.approach_step_value != 3'b111) cfg_next.approach_step_value
                         = cfg_reg.approach_step_value + 3'b001;
                2'b10: if (cfg_reg.approach_step_value != 3'b000) cfg_next.approach_step_value
                         = cfg_reg.approach_step_value - 3'b001;
                default: ;
              endcase
            end else begin
              step_cnt_next = step_cnt_reg + 3'b001;
            end
          end else begin
            trig_cnt_next = trig_cnt_reg + 2'b01;
          end
        end
      end
    end
    reload_next = ctl_next.load_bank_select ? cfg_next.secondary_width_preload
                  : cfg_next.primary_width_preload; // R01
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      ctl_reg <= '0;
      cfg_reg <= '0;
      tstate_reg <= pwa_pkg::TS_OFF;
      timer_reg <= `T_RST;
      rv_cnt_reg <= 8'h00;
      rv_active_reg <= 1'b0;
      sw_active_reg <= 1'b0;
      f1_reg <= 1'b0;
      f2_reg <= 1'b0;
      trig_cnt_reg <= 2'b00;
      step_cnt_reg <= 3'b000;
      fault_prev_reg <= 3'b111;
      rv_prev_reg <= 1'b1;
      trig_prev_reg <= 1'b0;
      reload_width <= `W_RST;
      phase_timer_overflow_signal <= 1'b0;
    end else begin
      ctl_reg <= ctl_next;
      cfg_reg <= cfg_next;
      tstate_reg <= tstate_next;
      timer_reg <= timer_next;
      rv_cnt_reg <= rv_cnt_next;
      rv_active_reg <= rv_active_next;
      sw_active_reg <= sw_active_next;
      f1_reg <= f1_next;
      f2_reg <= f2_next;
      trig_cnt_reg <= trig_cnt_next;
      step_cnt_reg <= step_cnt_next;
      fault_prev_reg <= comparator_fault_input;
      rv_prev_reg <= reverse_voltage_detect;
      trig_prev_reg <= phase_timer_trigger_input;
      reload_width <= reload_next;
      phase_timer_overflow_signal <= ovf_next;
    end
  end

  // checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  sequence s_fault_edge;
    |(fault_prev_reg & ~comparator_fault_input & ctl_reg.fault_reload_enable);
  endsequence
  sequence s_rv_fall;
    rv_prev_reg && !reverse_voltage_detect;
  endsequence
  a_bank_source: assert property (reload_width == (ctl_reg.load_bank_select
    ? cfg_reg.secondary_width_preload : cfg_reg.primary_width_preload)) else $error("reload source wrong"); // R01
  a_fault_bank: assert property (s_fault_edge |=> ctl_reg.load_bank_select)
    else $error("fault edge missed"); // R02
  a_rv_first: assert property (s_rv_fall |=> cfg_reg.primary_width_preload ==
    sat_add($past(cfg_reg.primary_width_preload), $past(cfg_reg.reverse_step_size)) && rv_active_reg)
    else $error("reverse first step wrong"); // R03
  a_rv_stop: assert property (rv_active_reg && reverse_voltage_detect && !rv_prev_reg |=> !rv_active_reg)
    else $error("reverse stepping kept on"); // R05
  a_rv_clamp: assert property (rv_active_reg && !reverse_voltage_detect |=>
    cfg_reg.primary_width_preload >= $past(cfg_reg.primary_width_preload)) else $error("width wrapped"); // R25
  a_hw_run_clear: assert property (hw_rise |=> !ctl_reg.phase_timer_run && tstate_reg == pwa_pkg::TS_OFF)
    else $error("run not cleared"); // R23
  a_hw_stop: assert property (wr_ctrl && !hwdata[`B_HW] |=> tstate_reg == pwa_pkg::TS_OFF)
    else $error("hardware approach not stopped"); // R22
  a_start_flags: assert property (hw_start |=> tstate_reg == pwa_pkg::TS_FIRST && !f1_reg && !f2_reg
    && timer_reg == $past(cfg_reg.first_phase_preload)) else $error("start wrong"); // R13
  a_first_hold: assert property (tstate_reg == pwa_pkg::TS_FIRST && ctl_reg.approach_hw_mode
    && reverse_voltage_detect && !rv_active_reg && !wr_en |=> $stable(cfg_reg.primary_width_preload))
    else $error("width moved in first interval"); // R14
  a_sw_active: assert property (wr_ctrl && hwdata[`B_EN] && !hwdata[`B_HW] |=> sw_active_reg)
    else $error("approach not active"); // R07
  a_timer_ovf: assert property (!ctl_reg.approach_hw_mode && ctl_reg.phase_timer_run && phase_timer_tick
    && timer_reg == `T_MAX && !run_rise |=> phase_timer_overflow_signal ##1 !phase_timer_overflow_signal)
    else $error("overflow pulse wrong"); // R10
endmodule

//--- pwa_consts.svh
// register offsets, field positions, reset values and limits of the width-adjust block
// included by the package user; definitions only
`ifndef PWA_CONSTS_SVH
`define PWA_CONSTS_SVH
`define OFF_CTRL 8'h00
`define OFF_HIGH 8'h04
`define OFF_PRI 8'h08
`define OFF_SEC 8'h0C
`define OFF_TGT1 8'h10
`define OFF_TGT2 8'h14
`define OFF_RV 8'h18
`define OFF_APR 8'h1C
`define OFF_PRE 8'h20
`define OFF_TMR 8'h24
`define B_LBS 0
`define B_FRE 3:1
`define B_HW 4
`define B_EN 5
`define B_TSEL 6
`define B_TRIG 7
`define B_RUN 8
`define B_ACT 9
`define B_STATE 11:10
`define B_F1 12
`define B_F2 13
`define F_STEP 3:0
`define F_IVL 7:4
`define F_TPS 1:0
`define F_SA 4:2
`define F_AFTER 7:5
`define F_TCC 9:8
`define F_SVC 11:10
`define F_PRE1 7:0
`define F_PRE2 15:8
`define F_PRE3 23:16
`define W_MAX 9'h1FF
`define W_RST 9'h000
`define T_MAX 8'hFF
`define T_RST 8'h00
`define RV_UNIT 8'h10
`endif

//--- pwa_pkg.sv
// types shared by the width-adjust block
// no imports; users write pwa_pkg::name
package pwa_pkg;
  typedef enum logic [1:0] {
    TS_FIRST = 2'b00,
    TS_TOWARD1 = 2'b01,
    TS_TOWARD2 = 2'b10,
    TS_OFF = 2'b11
  } timer_state_t;
  typedef struct packed {
    logic load_bank_select;
    logic [2:0] fault_reload_enable;
    logic approach_hw_mode;
    logic approach_enable;
    logic approach_target_select;
    logic phase_trigger_select;
    logic phase_timer_run;
  } ctl_t;
  typedef struct packed {
    logic [8:0] primary_width_preload;
    logic [8:0] secondary_width_preload;
    logic [8:0] first_approach_target;
    logic [8:0] second_approach_target;
    logic width_high_bits;
    logic [3:0] reverse_step_size;
    logic [3:0] reverse_step_interval;
    logic [1:0] triggers_per_step;
    logic [2:0] approach_step_value;
    logic [2:0] adjust_after_steps;
    logic [1:0] trigger_count_change;
    logic [1:0] step_value_change;
    logic [7:0] first_phase_preload;
    logic [7:0] second_phase_preload;
    logic [7:0] third_phase_preload;
  } cfg_t;
endpackage

//--- pwa_far_side.sv
// model of the comparator fault, reverse-detect, trigger and timer-tick sources
// assumes its tasks are called right after a rising core_clk edge
`timescale 1ns/100ps
module pwa_far_side (
  // clock
  input wire logic core_clk,
  // sources seen by the block
  output logic [2:0] comparator_fault_input,
  output logic reverse_voltage_detect,
  output logic phase_timer_trigger_input,
  output logic pulse_trigger,
  output logic phase_timer_tick
);
  initial begin
    comparator_fault_input = 3'h7;
    reverse_voltage_detect = 1'b1;
    phase_timer_trigger_input = 1'b0;
    pulse_trigger = 1'b0;
    phase_timer_tick = 1'b0;
  end
  // one falling edge, then back high
  task automatic fall(input int i);
    @(posedge core_clk) comparator_fault_input <= comparator_fault_input & ~(3'h1 << i);
    repeat (2) @(posedge core_clk);
    comparator_fault_input <= comparator_fault_input | (3'h1 << i);
  endtask
  task automatic rv(input logic v);
    @(posedge core_clk) reverse_voltage_detect <= v;
  endtask
  task automatic trig();
    @(posedge core_clk) phase_timer_trigger_input <= !phase_timer_trigger_input;
    repeat (2) @(posedge core_clk);
    phase_timer_trigger_input <= !phase_timer_trigger_input;
  endtask
  // n one-cycle pulses on the trigger line, or on the tick line
  task automatic pulses(input int n, input logic tk);
    repeat (n) begin
      @(posedge core_clk) pulse_trigger <= !tk;
      phase_timer_tick <= tk;
      @(posedge core_clk) pulse_trigger <= 1'b0;
      phase_timer_tick <= 1'b0;
    end
  endtask
endmodule

//--- pulse_width_adjust_control_tb_top.sv
// self-checking bench for the pulse width adjust control block
// assumes a single AHB-Lite master and the far-side model
`timescale 1ns/100ps
`include "pwa_consts.svh"
module pulse_width_adjust_control_tb_top;
  logic core_clk, reset_n, hsel, hwrite, hreadyout, hresp, ovf, rvd, tin, ptr, tck;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans;
  logic [2:0] hsize, cfi;
  logic [8:0] reload_width;
  int fails = 0;
  int compares = 0;
  int ovf_n = 0;
  pulse_width_adjust_control pulse_width_adjust_control_inst (.core_clk(core_clk), .reset_n(reset_n),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .comparator_fault_input(cfi),
    .reverse_voltage_detect(rvd), .phase_timer_trigger_input(tin), .pulse_trigger(ptr),
    .phase_timer_tick(tck), .reload_width(reload_width), .phase_timer_overflow_signal(ovf));
  pwa_far_side pwa_far_side_inst (.core_clk(core_clk), .comparator_fault_input(cfi),
    .reverse_voltage_detect(rvd), .phase_timer_trigger_input(tin), .pulse_trigger(ptr), .phase_timer_tick(tck));
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  always @(posedge core_clk) if (ovf === 1'b1) ovf_n++;
  task automatic report_and_stop();
    $display("compares=%0d fails=%0d", compares, fails);
    if (fails == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      fails++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wt();
    int k = 0;
    do begin
      @(posedge core_clk);
      k++;
    end while (hreadyout !== 1'b1 && k < 50);
    if (hreadyout !== 1'b1) fails++;
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {24'h0, a};
    hwrite <= w;
    hsize <= 3'b010;
    wt();
    htrans <= 2'b00;
    hsel <= 1'b0;
    hwdata <= d;
    wt();
    q = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rc(input string n, input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(n, e & m, q & m);
    chk("hresp", 32'h0, {31'h0, hresp});
  endtask
  initial begin
    repeat (5000) @(posedge core_clk);
    fails++;
    report_and_stop();
  end
  initial begin
    reset_n = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = 32'h0;
    repeat (2) @(posedge core_clk);
    reset_n <= 1'b1;
    @(posedge core_clk);
    rc("ctrl", `OFF_CTRL, 32'h00000C00, 32'h00003FFF);
    wr(8'h40, 32'hFFFFFFFF);
    rc("unmapped", 8'h40, 32'h0, 32'hFFFFFFFF);
    wr(`OFF_HIGH, 32'h1);
    wr(`OFF_PRI, 32'h23);
    wr(`OFF_HIGH, 32'h0);
    wr(`OFF_SEC, 32'h45);
    rc("pri", `OFF_PRI, 32'h123, 32'h1FF);
    chk("reload", 32'h123, {23'h0, reload_width});
    wr(`OFF_CTRL, 32'h1);
    repeat (2) @(posedge core_clk);
    chk("reload", 32'h045, {23'h0, reload_width});
    wr(`OFF_CTRL, 32'h0);
    pwa_far_side_inst.fall(1);
    rc("bank", `OFF_CTRL, 32'h0, 32'h1);
    wr(`OFF_CTRL, 32'h4);
    pwa_far_side_inst.fall(1);
    rc("bank", `OFF_CTRL, 32'h5, 32'hF);
    chk("reload", 32'h045, {23'h0, reload_width});
    wr(`OFF_CTRL, 32'h0);
    wr(`OFF_HIGH, 32'h1);
    wr(`OFF_PRI, 32'h0);
    wr(`OFF_RV, 32'h18);
    pwa_far_side_inst.rv(1'b0);
    repeat (6) @(posedge core_clk);
    rc("pri", `OFF_PRI, 32'h108, 32'h1FF);
    repeat (12) @(posedge core_clk);
    rc("pri", `OFF_PRI, 32'h110, 32'h1FF);
    pwa_far_side_inst.rv(1'b1);
    repeat (30) @(posedge core_clk);
    rc("pri", `OFF_PRI, 32'h110, 32'h1FF);
    wr(`OFF_PRI, 32'hF8);
    pwa_far_side_inst.rv(1'b0);
    repeat (40) @(posedge core_clk);
    rc("pri", `OFF_PRI, 32'h1FF, 32'h1FF);
    pwa_far_side_inst.rv(1'b1);
    wr(`OFF_PRI, 32'h0);
    wr(`OFF_TGT1, 32'h0C);
    wr(`OFF_APR, 32'h0C);
    wr(`OFF_CTRL, 32'h20);
    rc("active", `OFF_CTRL, 32'h220, 32'h3220);
    pwa_far_side_inst.pulses(2, 1'b0);
    rc("pri", `OFF_PRI, 32'h108, 32'h1FF);
    rc("flags", `OFF_CTRL, 32'h0, 32'h3000);
    pwa_far_side_inst.pulses(2, 1'b0);
    rc("pri", `OFF_PRI, 32'h10C, 32'h1FF);
    rc("flags", `OFF_CTRL, 32'h1000, 32'h3000);
    pwa_far_side_inst.rv(1'b0);
    repeat (6) @(posedge core_clk);
    rc("pri", `OFF_PRI, 32'h114, 32'h1FF);
    pwa_far_side_inst.rv(1'b1);
    wr(`OFF_CTRL, 32'h0);
    wr(`OFF_PRI, 32'h0);
    wr(`OFF_APR, 32'h20C);
    wr(`OFF_PRE, 32'hFD);
    wr(`OFF_CTRL, 32'h100);
    ovf_n = 0;
    pwa_far_side_inst.pulses(6, 1'b1);
    repeat (2) @(posedge core_clk);
    chk("overflow", 32'h2, ovf_n);
    wr(`OFF_CTRL, 32'h110);
    rc("run", `OFF_CTRL, 32'hC10, 32'hD10);
    pwa_far_side_inst.trig();
    rc("state", `OFF_CTRL, 32'h0, 32'hC00);
    pwa_far_side_inst.pulses(2, 1'b0);
    rc("pri", `OFF_PRI, 32'h100, 32'h1FF);
    pwa_far_side_inst.pulses(4, 1'b1);
    rc("state", `OFF_CTRL, 32'h400, 32'hC00);
    pwa_far_side_inst.pulses(1, 1'b0);
    rc("pri", `OFF_PRI, 32'h104, 32'h1FF);
    pwa_far_side_inst.pulses(1, 1'b0);
    rc("pri", `OFF_PRI, 32'h104, 32'h1FF);
    pwa_far_side_inst.pulses(8, 1'b0);
    rc("pri", `OFF_PRI, 32'h10C, 32'h1FF);
    rc("flag1", `OFF_CTRL, 32'h1000, 32'h1000);
    wr(`OFF_PRI, 32'h0);
    rc("pri", `OFF_PRI, 32'h10C, 32'h1FF);
    wr(`OFF_CTRL, 32'h10);
    rc("flag1", `OFF_CTRL, 32'h1000, 32'h1000);
    pwa_far_side_inst.pulses(255, 1'b1);
    rc("state", `OFF_CTRL, 32'h800, 32'hC00);
    wr(`OFF_CTRL, 32'h10);
    rc("flag1", `OFF_CTRL, 32'h0, 32'h1000);
    pwa_far_side_inst.pulses(4, 1'b0);
    rc("pri", `OFF_PRI, 32'h108, 32'h1FF);
    wr(`OFF_CTRL, 32'h0);
    rc("state", `OFF_CTRL, 32'hC00, 32'hC10);
    wr(`OFF_CTRL, 32'h90);
    wr(`OFF_CTRL, 32'h190);
    rc("run start", `OFF_CTRL, 32'h190, 32'hD90);
    report_and_stop();
  end
endmodule
